/* File: bench/node_master_model.sv */
// behavioural fieldbus master that parameterises and configures the node
`timescale 1ns/100ps
module node_master_model
  import node_status_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bench control
  input wire logic go_in,
  input wire node_status_pkg::slot_cfg_s want1_in,
  input wire node_status_pkg::slot_cfg_s want2_in,
  // towards the node
  output logic bus_up_out,
  output logic param_ok_out,
  output logic cfg_valid_out,
  output node_status_pkg::slot_cfg_s cfg1_out,
  output node_status_pkg::slot_cfg_s cfg2_out
);
  import node_status_pkg::*;
  logic [1:0] step;
  ////////////////////////////////////////
  // every node restart restarts the sequence, so the configuration goes out again
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      step <= 2'h0;
    else if (!go_in)
      step <= 2'h0;
    else if (step != 2'h3)
      step <= step + 2'h1;
  end
  assign bus_up_out = (step != 2'h0);
  assign param_ok_out = (step != 2'h0);
  assign cfg_valid_out = step[1];
  // an idle configuration bus shows the inverse pattern, never a stale copy
  assign cfg1_out = cfg_valid_out ? want1_in : ~want1_in;
  assign cfg2_out = cfg_valid_out ? want2_in : ~want2_in;
endmodule

/* File: bench/node_status_bench.sv */
// self-checking bench of the node start-up and indicator block
`timescale 1ns/100ps
module node_status_bench;
  import node_status_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  slot_cfg_s want1 = '0;
  slot_cfg_s want2 = '0;
  logic bus_up, param_ok, cfg_valid, diag_send, exch, irq, tool, ok;
  slot_cfg_s cfg1, cfg2;
  logic diag_req = 1'b0;
  logic oper_ok = 1'b1;
  logic oper_uv = 1'b0;
  device_s dev1 = '0;
  device_s dev2 = '0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, got, r;
  logic [7:0] cs, as;
  indicator_s sup, lnk1, lnk2, bf;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h1d4741ad;
  always #10 clk = ~clk;
  ////////////////////////////////////////
  node_master_model u_node_master_model (.clk_in(clk), .rst_in(rst), .go_in(go),
    .want1_in(want1), .want2_in(want2), .bus_up_out(bus_up), .param_ok_out(param_ok),
    .cfg_valid_out(cfg_valid), .cfg1_out(cfg1), .cfg2_out(cfg2));
  node_status u_node_status (.CLK_IN(clk), .RST_IN(rst), .BUS_UP_IN(bus_up),
    .PARAM_OK_IN(param_ok), .CONFIG_VALID_IN(cfg_valid), .CFG1_IN(cfg1), .CFG2_IN(cfg2),
    .DIAG_REQ_IN(diag_req), .DIAG_SEND_OUT(diag_send), .EXCHANGE_OUT(exch),
    .OPER_OK_IN(oper_ok), .OPER_UNDERVOLT_IN(oper_uv), .DEV1_IN(dev1), .DEV2_IN(dev2),
    .SUPPLY_INDICATOR_OUT(sup), .FIRST_LINK_INDICATOR_OUT(lnk1),
    .SECOND_LINK_INDICATOR_OUT(lnk2), .BUS_FAULT_INDICATOR_OUT(bf), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq));
  ////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_ind(input string what, input indicator_s exp, input indicator_s seen);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // devices are fitted before reset ends, as at a real power-up
  task automatic restart(input device_s d1, input device_s d2);
    rst <= 1'b1;
    go <= 1'b0;
    dev1 <= d1;
    dev2 <= d2;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
  endtask
  // state and indicators each trail their cause by one edge
  task automatic start(input slot_cfg_s c1, input slot_cfg_s c2, input logic t);
    if (t)
      reg_wr(ADDR_CTRL, 32'h2);
    want1 <= c1;
    want2 <= c2;
    go <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  function automatic device_s mk_dev(input logic [7:0] s);
    mk_dev = '0;
    mk_dev.present = 1'b1;
    mk_dev.run = 1'b1;
    mk_dev.actual_size = s;
  endfunction
  function automatic logic fits(input slot_cfg_s c, input device_s d, input logic t);
    if (!c.configured)
      return !d.present;
    return d.present && (t ? d.actual_size <= c.size : d.actual_size == c.size);
  endfunction
  ////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial
  begin
    restart(mk_dev(8'h08), '0);
    reg_rd(ADDR_CTRL);
    chk_word("ctrl", 32'h0, got);
    start({1'b1, 8'h08}, '0, 1'b0);
    chk_word("exchange", 32'h1, {31'h0, exch});
    chk_ind("bus fault", '0, bf);
    chk_ind("first link", 3'b001, lnk1);
    chk_ind("supply", 3'b001, sup);
    reg_rd(ADDR_STATUS);
    chk_word("status", 32'he, got);
    reg_rd(ADDR_IRQ_STAT);
    chk_word("irq status", 32'h2, got);
    chk_word("irq masked", 32'h0, {31'h0, irq});
    reg_wr(ADDR_IRQ_MASK, 32'h2);
    chk_word("irq", 32'h1, {31'h0, irq});
    reg_wr(ADDR_IRQ_STAT, 32'h2);
    chk_word("irq cleared", 32'h0, {31'h0, irq});
    reg_rd(4'h2);
    chk_word("unmapped", 32'h0, got);
    $display("test start-up and registers done");
    diag_req <= 1'b1;
    settle();
    chk_word("diag off", 32'h0, {31'h0, diag_send});
    reg_wr(ADDR_CTRL, 32'h1);
    chk_word("diag on", 32'h1, {31'h0, diag_send});
    oper_uv <= 1'b1;
    settle();
    chk_word("supply flash", 32'h1, {31'h0, sup.flash});
    oper_uv <= 1'b0;
    dev1.load_undervolt <= 1'b1;
    settle();
    chk_ind("supply unused load", 3'b001, sup);
    dev1.uses_load <= 1'b1;
    settle();
    chk_word("supply load flash", 32'h1, {31'h0, sup.flash});
    oper_ok <= 1'b0;
    settle();
    chk_ind("supply off", '0, sup);
    oper_ok <= 1'b1;
    $display("test diagnostics and supply done");
    restart('0, '0);
    dev1 <= mk_dev(8'h08);
    start({1'b1, 8'h08}, '0, 1'b0);
    chk_word("late device", {31'h0, fits({1'b1, 8'h08}, '0, 1'b0)}, {31'h0, exch});
    chk_word("no device links", 32'h3, {30'h0, lnk1.flash, lnk2.flash});
    $display("test late device done");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      tool = (i < 3) ? 1'b1 : r[8];
      cs = {1'b0, r[6:0]} + 8'h04;
      as = cs + 8'(i % 3) - 8'h01;
      restart(mk_dev(as), '0);
      start({1'b1, cs}, '0, tool);
      ok = fits({1'b1, cs}, mk_dev(as), tool);
      chk_word("exchange", {31'h0, ok}, {31'h0, exch});
      if (ok)
        chk_ind("bus fault", '0, bf);
      else
      begin
        chk_word("bus fault flash", 32'h1, {31'h0, bf.flash});
        chk_word("link flash", 32'h3, {30'h0, lnk1.flash, lnk2.flash});
        reg_rd(ADDR_STATUS);
        chk_word("status", 32'h2d, got);
      end
    end
    $display("test size matching done");
    close_out();
  end
endmodule

/* File: rtl/node_status.sv */
// start-up checking, indicator drive and diagnostics gate of the bus node
// Operation
// - A configuration that does not match the attached devices keeps the node out of exchange.
// - While exchange is refused for a mismatch, the bus fault indicator flashes red slowly.
// - A configured device missing at power-up gives an error and no process data exchange.
// - In tool change mode any link device fits if its actual data size is within the configured.
// - The supply indicator is steady green when operating and load voltage are in range.
// - Each link indicator is steady green while its device is connected and running.
// - With fieldbus communication up in normal operation the bus fault indicator is dark.
// - A diagnostics switch gates device diagnostics to the master; off by default.
// - The supply indicator flashes green on an own or device-reported undervoltage.
// - The supply indicator is dark while the operating voltage is absent or out of range.
// - A device load undervoltage counts only where that device uses and monitors the load.
// - After power-up the node goes from awaiting parameters to configuration to exchange.
// - With no device attached or a configuration error both link indicators flash red.
`timescale 1ns/100ps
module node_status
  import node_status_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // fieldbus engine
  input wire logic BUS_UP_IN,
  input wire logic PARAM_OK_IN,
  input wire logic CONFIG_VALID_IN,
  input wire node_status_pkg::slot_cfg_s CFG1_IN,
  input wire node_status_pkg::slot_cfg_s CFG2_IN,
  input wire logic DIAG_REQ_IN,
  output logic DIAG_SEND_OUT,
  output logic EXCHANGE_OUT,
  // supply monitors
  input wire logic OPER_OK_IN,
  input wire logic OPER_UNDERVOLT_IN,
  // attached devices
  input wire node_status_pkg::device_s DEV1_IN,
  input wire node_status_pkg::device_s DEV2_IN,
  // indicators
  output node_status_pkg::indicator_s SUPPLY_INDICATOR_OUT,
  output node_status_pkg::indicator_s FIRST_LINK_INDICATOR_OUT,
  output node_status_pkg::indicator_s SECOND_LINK_INDICATOR_OUT,
  output node_status_pkg::indicator_s BUS_FAULT_INDICATOR_OUT,
  // register bus
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT
);
  import node_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // flash divider

  logic [DIV_W-1:0] div_cnt;
  logic slow_phase;
  logic fast_phase;
  wire slow_tick = (div_cnt == DIV_W'(SLOW_HALF_CYC - 1));
  // four fast half periods fill one slow half period, so the fast phase toggles at every quarter
  wire fast_tick = (div_cnt == DIV_W'(FAST_HALF_CYC - 1))
                 || (div_cnt == DIV_W'(2 * FAST_HALF_CYC - 1))
                 || (div_cnt == DIV_W'(3 * FAST_HALF_CYC - 1))
                 || (div_cnt == DIV_W'(SLOW_HALF_CYC - 1));

  // wrapping at the slow half period keeps both phases aligned
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      div_cnt <= '0;
      slow_phase <= 1'b0;
      fast_phase <= 1'b0;
    end
    else
    begin
      div_cnt <= slow_tick ? '0 : div_cnt + 1'b1;
      if (slow_tick)
        slow_phase <= ~slow_phase;
      if (fast_tick)
        fast_phase <= ~fast_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  link_state_e state;
  logic mismatch;
  logic dev1_at_start;
  logic dev2_at_start;
  logic start_seen;

  wire diag_enable = ctrl[CTRL_DIAG_EN];
  wire tool_change = ctrl[CTRL_TOOL_CHANGE];
  wire wr_ctrl = WR_IN && (ADDR_IN == ADDR_CTRL);
  wire wr_stat = WR_IN && (ADDR_IN == ADDR_IRQ_STAT);
  wire wr_mask = WR_IN && (ADDR_IN == ADDR_IRQ_MASK);

  assign status_word = {24'h0, 2'h0, mismatch, dev2_at_start, dev1_at_start, OPER_OK_IN, state};
  assign next_rdata = (ADDR_IN == ADDR_CTRL) ? {30'h0, ctrl} :
                      (ADDR_IN == ADDR_STATUS) ? status_word :
                      (ADDR_IN == ADDR_IRQ_STAT) ? {28'h0, irq_stat} :
                      (ADDR_IN == ADDR_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0;

  // diagnostics switch defaults off after reset
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ctrl <= CTRL_RESET;
      irq_mask <= '0;
      RDATA_OUT <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= WDATA_IN[1:0];
      if (wr_mask)
        irq_mask <= WDATA_IN[IRQ_W-1:0];
      RDATA_OUT <= RD_IN ? next_rdata : 32'h0;
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~(wr_stat ? WDATA_IN[IRQ_W-1:0] : '0)) | irq_event;
  end

  assign IRQ_OUT = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // configuration check

  // equipment present at the first clock after reset is latched as the start set;
  // a device plugged in later is never accepted until the next power-up
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      start_seen <= 1'b0;
      dev1_at_start <= 1'b0;
      dev2_at_start <= 1'b0;
    end
    else if (!start_seen)
    begin
      start_seen <= 1'b1;
      dev1_at_start <= DEV1_IN.present;
      dev2_at_start <= DEV2_IN.present;
    end
  end

  wire slot1_ok = !CFG1_IN.configured ? !dev1_at_start :
                  dev1_at_start && DEV1_IN.present &&
                  (tool_change ? (DEV1_IN.actual_size <= CFG1_IN.size)
                               : (DEV1_IN.actual_size == CFG1_IN.size));
  wire slot2_ok = !CFG2_IN.configured ? !dev2_at_start :
                  dev2_at_start && DEV2_IN.present &&
                  (tool_change ? (DEV2_IN.actual_size <= CFG2_IN.size)
                               : (DEV2_IN.actual_size == CFG2_IN.size));
  wire config_match = slot1_ok && slot2_ok;
  wire no_device = !dev1_at_start && !dev2_at_start;

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequence

  link_state_e next_state;
  logic next_mismatch;

  always_comb
  begin
    next_state = state;
    next_mismatch = mismatch;
    case (state)
      AWAIT_PARAMETERS_STATE:
      begin
        if (BUS_UP_IN && PARAM_OK_IN)
          next_state = AWAIT_CONFIGURATION_STATE;
      end
      AWAIT_CONFIGURATION_STATE:
      begin
        if (!BUS_UP_IN)
          next_state = AWAIT_PARAMETERS_STATE;
        else if (CONFIG_VALID_IN)
        begin
          next_mismatch = !config_match || no_device;
          if (config_match && !no_device)
            next_state = CYCLIC_EXCHANGE_STATE;
        end
      end
      CYCLIC_EXCHANGE_STATE:
      begin
        if (!BUS_UP_IN)
          next_state = AWAIT_PARAMETERS_STATE;
        else if (!config_match)
        begin
          next_state = AWAIT_CONFIGURATION_STATE;
          next_mismatch = 1'b1;
        end
      end
      default:
        next_state = AWAIT_PARAMETERS_STATE;
    endcase
  end

  // the master must resend configuration after every reset, so nothing is kept
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state <= AWAIT_PARAMETERS_STATE;
      mismatch <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mismatch <= next_mismatch;
    end
  end

  wire exchange = (state == CYCLIC_EXCHANGE_STATE);
  wire load_uv = (DEV1_IN.present && DEV1_IN.uses_load && DEV1_IN.load_undervolt) ||
                 (DEV2_IN.present && DEV2_IN.uses_load && DEV2_IN.load_undervolt);
  wire undervolt = OPER_UNDERVOLT_IN || load_uv;

  assign irq_event = {(state == CYCLIC_EXCHANGE_STATE) && !BUS_UP_IN,
                      undervolt,
                      (next_state == CYCLIC_EXCHANGE_STATE) && !exchange,
                      next_mismatch && !mismatch};
  assign EXCHANGE_OUT = exchange;
  assign DIAG_SEND_OUT = DIAG_REQ_IN && diag_enable && exchange;

  ////////////////////////////////////////////////////////////////////////////
  // indicators

  indicator_s next_supply;
  indicator_s next_link1;
  indicator_s next_link2;
  indicator_s next_bus;

  always_comb
  begin
    if (!OPER_OK_IN)
      next_supply = '{flash: 1'b0, colour: IND_DARK};
    else if (undervolt)
      next_supply = '{flash: 1'b1, colour: slow_phase ? IND_GREEN : IND_DARK};
    else
      next_supply = '{flash: 1'b0, colour: IND_GREEN};
  end

  wire link_err = no_device || mismatch;

  always_comb
  begin
    if (link_err)
    begin
      next_link1 = '{flash: 1'b1, colour: fast_phase ? IND_RED : IND_DARK};
      next_link2 = '{flash: 1'b1, colour: fast_phase ? IND_RED : IND_DARK};
    end
    else
    begin
      next_link1 = '{flash: 1'b0,
                     colour: (DEV1_IN.present && DEV1_IN.run) ? IND_GREEN : IND_DARK};
      next_link2 = '{flash: 1'b0,
                     colour: (DEV2_IN.present && DEV2_IN.run) ? IND_GREEN : IND_DARK};
    end
  end

  always_comb
  begin
    if (mismatch && !exchange)
      next_bus = '{flash: 1'b1, colour: slow_phase ? IND_RED : IND_DARK};
    else if (!BUS_UP_IN)
      next_bus = '{flash: 1'b0, colour: IND_RED};
    else if (exchange)
      next_bus = '{flash: 1'b0, colour: IND_DARK};
    else
      next_bus = '{flash: 1'b1, colour: fast_phase ? IND_RED : IND_DARK};
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      SUPPLY_INDICATOR_OUT <= '0;
      FIRST_LINK_INDICATOR_OUT <= '0;
      SECOND_LINK_INDICATOR_OUT <= '0;
      BUS_FAULT_INDICATOR_OUT <= '0;
    end
    else
    begin
      SUPPLY_INDICATOR_OUT <= next_supply;
      FIRST_LINK_INDICATOR_OUT <= next_link1;
      SECOND_LINK_INDICATOR_OUT <= next_link2;
      BUS_FAULT_INDICATOR_OUT <= next_bus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence cfg_check_bad;
    state == AWAIT_CONFIGURATION_STATE && BUS_UP_IN && CONFIG_VALID_IN && !config_match;
  endsequence

  mismatch_refused_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cfg_check_bad |=> state != CYCLIC_EXCHANGE_STATE && mismatch)
    else $error("exchange entered despite mismatch");

  bus_flash_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mismatch && !exchange |=> BUS_FAULT_INDICATOR_OUT.flash &&
      BUS_FAULT_INDICATOR_OUT.colour != IND_GREEN)
    else $error("bus fault not flashing on mismatch");

  missing_device_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    start_seen && CFG1_IN.configured && !dev1_at_start |-> !config_match)
    else $error("missing device accepted");

  supply_green_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    OPER_OK_IN && !undervolt |=>
      SUPPLY_INDICATOR_OUT == indicator_s'{flash: 1'b0, colour: IND_GREEN})
    else $error("supply indicator not steady green");

  bus_dark_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    exchange && BUS_UP_IN |=> BUS_FAULT_INDICATOR_OUT.colour == IND_DARK)
    else $error("bus fault lit in normal operation");

  diag_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    DIAG_SEND_OUT |-> diag_enable && DIAG_REQ_IN)
    else $error("diagnostics sent while switched off");

  supply_dark_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !OPER_OK_IN |=> SUPPLY_INDICATOR_OUT.colour == IND_DARK)
    else $error("supply lit without operating voltage");

  state_order_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state == AWAIT_PARAMETERS_STATE |=> state != CYCLIC_EXCHANGE_STATE)
    else $error("exchange reached without configuration step");

  links_together_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    link_err |=> FIRST_LINK_INDICATOR_OUT == SECOND_LINK_INDICATOR_OUT &&
      FIRST_LINK_INDICATOR_OUT.flash)
    else $error("link indicators not flashing together");
endmodule

/* File: rtl/node_status_pkg.sv */
// constants, types and register map of the node start-up and indicator block
package node_status_pkg;
  // indicator colour codes
  typedef enum logic [1:0] {
    IND_DARK = 2'b00,
    IND_GREEN = 2'b01,
    IND_RED = 2'b10
  } colour_e;

  // one indicator: colour and whether it flashes
  typedef struct packed {
    logic flash;
    logic [1:0] colour;
  } indicator_s;

  // link start-up states
  typedef enum logic [1:0] {
    AWAIT_PARAMETERS_STATE = 2'b00,
    AWAIT_CONFIGURATION_STATE = 2'b01,
    CYCLIC_EXCHANGE_STATE = 2'b10
  } link_state_e;

  // per-device report from an attached link device
  typedef struct packed {
    logic present;
    logic run;
    logic uses_load;
    logic load_undervolt;
    logic [7:0] actual_size;
  } device_s;

  // master configuration for one device slot
  typedef struct packed {
    logic configured;
    logic [7:0] size;
  } slot_cfg_s;

  // timing: flash rates derived from the 50 MHz clock
  localparam int CLK_HZ = 50000000;
  localparam int SLOW_FLASH_HZ = 1;
  localparam int FAST_FLASH_HZ = 4;
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
  localparam int DIV_W = 25;

  // register bus
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // control register fields
  localparam int CTRL_DIAG_EN = 0;
  localparam int CTRL_TOOL_CHANGE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // interrupt status bit positions
  localparam int IRQ_MISMATCH = 0;
  localparam int IRQ_EXCHANGE = 1;
  localparam int IRQ_UNDERVOLT = 2;
  localparam int IRQ_BUS_LOST = 3;
  localparam int IRQ_W = 4;
endpackage
